/* File: segacq_pkg.sv */
// Constants and register map of the segmented acquisition controller.
package segacq_pkg;
    // ========================================
    // Register offsets
    localparam logic [15:0] OFF_MODE      = 16'h251c;
    localparam logic [15:0] OFF_TOTAL_LO  = 16'h2710;
    localparam logic [15:0] OFF_TOTAL_HI  = 16'h2711;
    localparam logic [15:0] OFF_SEGLEN_LO = 16'h271a;
    localparam logic [15:0] OFF_SEGLEN_HI = 16'h271b;
    localparam logic [15:0] OFF_LOOPS     = 16'h2724;
    localparam logic [15:0] OFF_POST_LO   = 16'h2774;
    localparam logic [15:0] OFF_POST_HI   = 16'h2775;
    localparam logic [15:0] OFF_CTRL      = 16'h2800;
    localparam logic [15:0] OFF_STATUS    = 16'h2801;
    localparam logic [15:0] OFF_IRQ_STS   = 16'h2802;
    localparam logic [15:0] OFF_IRQ_MASK  = 16'h2803;
    localparam logic [15:0] OFF_CHANNELS  = 16'h2804;
    localparam logic [15:0] OFF_SEG_DONE  = 16'h2805;
    localparam logic [15:0] OFF_PRE       = 16'h2806;
    // ========================================
    // Field codes and positions
    localparam logic [31:0] MODE_BOUNDED = 32'h0000_0002;
    localparam logic [31:0] MODE_STREAM  = 32'h0000_0020;
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP  = 1;
    localparam int IRQ_SEG    = 0;
    localparam int IRQ_DONE   = 1;
    localparam int IRQ_ERR    = 2;
    localparam int IRQ_W      = 3;
    localparam logic [2:0] CH_ONE  = 3'h1;
    localparam logic [2:0] CH_TWO  = 3'h2;
    localparam logic [2:0] CH_FOUR = 3'h4;
    localparam logic [63:0] PRE_MAX_1CH = 64'h0000_0000_0000_1ff0;
    localparam logic [63:0] PRE_MAX_2CH = 64'h0000_0000_0000_0ff8;
    localparam logic [63:0] PRE_MAX_4CH = 64'h0000_0000_0000_07fc;
    localparam logic [63:0] SAMPLE_BYTES = 64'h0000_0000_0000_0002;
    // ========================================
    // Reset values
    localparam logic [31:0] RST_MODE  = 32'h0000_0000;
    localparam logic [63:0] RST_CNT   = 64'h0000_0000_0000_0000;
    localparam logic [31:0] RST_LOOPS = 32'h0000_0000;
    localparam logic [2:0]  RST_CHANS = 3'h1;
    localparam logic [2:0]  RST_MASK  = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRE  = 2'b01,
        ST_POST = 2'b10
    } acq_state_t;
endpackage

/* File: segacq_ctrl.sv */
// Segmented trigger acquisition controller with register port and interrupt.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
module segacq_ctrl
    import segacq_pkg::*;
#(
    parameter logic [63:0] MEM_SAMPLES = 64'h0000_0000_0200_0000
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Sample and trigger stream
    input  wire logic        sample_valid,
    input  wire logic        trigger_in,
    // Sample memory write side
    output logic             mem_wr,
    output logic      [63:0] mem_byte_addr,
    // Segment hand-over to the host transfer engine
    output logic             seg_ready,
    output logic      [63:0] seg_byte_base,
    // Status
    output logic             acq_busy,
    output logic             irq
);
    // ========================================
    // State
    typedef struct packed {
        acq_state_t        st;
        logic [31:0]       mode;
        logic [63:0]       total;
        logic [63:0]       seglen;
        logic [63:0]       post;
        logic [31:0]       loops;
        logic [2:0]        chans;
        logic [IRQ_W-1:0]  irq_sts;
        logic [IRQ_W-1:0]  irq_mask;
        logic [63:0]       pre;
        logic [63:0]       ptr;
        logic [63:0]       cnt;
        logic [63:0]       base;
        logic [63:0]       filled;
        logic [31:0]       segs;
        logic              stream;
        logic [31:0]       rdata;
        logic              mem_wr;
        logic [63:0]       mem_addr;
        logic              seg_ready;
        logic [63:0]       seg_base;
    } state_t;

    state_t           q;
    state_t           d;
    logic             start_req;
    logic             stop_req;
    logic             cfg_bad;
    logic             mode_ok;
    logic             seg_end;
    logic [63:0]      pre_calc;
    logic [63:0]      pre_max;
    logic [63:0]      ptr_nxt;
    logic [63:0]      base_nxt;
    logic [63:0]      cnt_nxt;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;

    // ========================================
    // Next-state logic
    always_comb begin
        d           = q;
        d.mem_wr    = 1'b0;
        d.seg_ready = 1'b0;
        d.rdata     = 32'h0000_0000;
        ev          = '0;
        w1c         = '0;
        start_req   = 1'b0;
        stop_req    = 1'b0;
        seg_end     = 1'b0;
        cnt_nxt     = q.cnt + 64'h1;
        pre_calc    = q.seglen - q.post;
        unique case (q.chans)
            CH_TWO:  pre_max = PRE_MAX_2CH;
            CH_FOUR: pre_max = PRE_MAX_4CH;
            default: pre_max = PRE_MAX_1CH;
        endcase
        cfg_bad = (q.post == RST_CNT) || (q.post > q.seglen) || (pre_calc > pre_max);
        mode_ok = (q.mode == MODE_BOUNDED) || (q.mode == MODE_STREAM);
        // The pointer wraps inside one segment, so pre-trigger samples form a ring.
        ptr_nxt = (q.ptr + 64'h1 == q.seglen) ? RST_CNT : q.ptr + 64'h1;
        base_nxt = q.base + q.seglen;
        if (q.stream && (base_nxt + q.seglen > MEM_SAMPLES)) begin
            base_nxt = RST_CNT;
        end

        // Configuration other than the interrupt mask is frozen while an acquisition runs.
        if (reg_wr) begin
            unique case (reg_addr)
                OFF_CTRL: begin
                    start_req = reg_wdata[CTRL_START];
                    stop_req  = reg_wdata[CTRL_STOP];
                end
                OFF_IRQ_STS:  w1c = reg_wdata[IRQ_W-1:0];
                OFF_IRQ_MASK: d.irq_mask = reg_wdata[IRQ_W-1:0];
                default: begin
                    if (q.st == ST_IDLE) begin
                        unique case (reg_addr)
                            OFF_MODE:      d.mode = reg_wdata;
                            OFF_TOTAL_LO:  d.total[31:0] = reg_wdata;
                            OFF_TOTAL_HI:  d.total[63:32] = reg_wdata;
                            OFF_SEGLEN_LO: d.seglen[31:0] = reg_wdata;
                            OFF_SEGLEN_HI: d.seglen[63:32] = reg_wdata;
                            OFF_POST_LO:   d.post[31:0] = reg_wdata;
                            OFF_POST_HI:   d.post[63:32] = reg_wdata;
                            OFF_LOOPS:     d.loops = reg_wdata;
                            OFF_CHANNELS:  d.chans = reg_wdata[2:0];
                            default:       d.chans = q.chans;
                        endcase
                    end
                end
            endcase
        end

        if (reg_rd) begin
            unique case (reg_addr)
                OFF_MODE:      d.rdata = q.mode;
                OFF_TOTAL_LO:  d.rdata = q.total[31:0];
                OFF_TOTAL_HI:  d.rdata = q.total[63:32];
                OFF_SEGLEN_LO: d.rdata = q.seglen[31:0];
                OFF_SEGLEN_HI: d.rdata = q.seglen[63:32];
                OFF_POST_LO:   d.rdata = q.post[31:0];
                OFF_POST_HI:   d.rdata = q.post[63:32];
                OFF_LOOPS:     d.rdata = q.loops;
                OFF_STATUS:    d.rdata = {30'h0, q.stream, q.st != ST_IDLE};
                OFF_IRQ_STS:   d.rdata = {29'h0, q.irq_sts};
                OFF_IRQ_MASK:  d.rdata = {29'h0, q.irq_mask};
                OFF_CHANNELS:  d.rdata = {29'h0, q.chans};
                OFF_SEG_DONE:  d.rdata = q.segs;
                OFF_PRE:       d.rdata = pre_calc[31:0];
                default:       d.rdata = 32'h0000_0000;
            endcase
        end

        unique case (q.st)
            ST_IDLE: begin
                if (start_req && mode_ok) begin
                    if (cfg_bad) begin
                        ev[IRQ_ERR] = 1'b1;
                    end else begin
                        d.st     = ST_PRE;
                        d.pre    = pre_calc;
                        d.stream = (q.mode == MODE_STREAM);
                        d.ptr    = RST_CNT;
                        d.cnt    = RST_CNT;
                        d.base   = RST_CNT;
                        d.filled = RST_CNT;
                        d.segs   = RST_LOOPS;
                    end
                end
            end
            ST_PRE: begin
                if (sample_valid) begin
                    d.mem_wr = 1'b1;
                    d.ptr    = ptr_nxt;
                    // A trigger counts only once the pre-trigger depth is full.
                    if (trigger_in && (q.cnt >= q.pre)) begin
                        d.st  = ST_POST;
                        d.cnt = 64'h1;
                        seg_end = (q.post == 64'h1);
                    end else if (q.cnt < q.pre) begin
                        d.cnt = cnt_nxt;
                    end
                end
            end
            ST_POST: begin
                if (sample_valid) begin
                    d.mem_wr = 1'b1;
                    d.ptr    = ptr_nxt;
                    d.cnt    = cnt_nxt;
                    seg_end  = (cnt_nxt == q.post);
                end
            end
            default: d.st = ST_IDLE;
        endcase
        d.mem_addr = 64'((q.base + q.ptr) * SAMPLE_BYTES);

        if (seg_end) begin
            ev[IRQ_SEG] = 1'b1;
            d.segs      = q.segs + 32'h1;
            d.filled    = q.filled + q.seglen;
            d.seg_ready = q.stream;
            d.seg_base  = 64'(q.base * SAMPLE_BYTES);
            d.base      = base_nxt;
            d.ptr       = RST_CNT;
            d.cnt       = RST_CNT;
            d.st        = ST_PRE;
            if (!q.stream && (q.filled + q.seglen >= q.total)) begin
                d.st = ST_IDLE;
                ev[IRQ_DONE] = 1'b1;
            end
            if (q.stream && (q.loops != RST_LOOPS) && (q.segs + 32'h1 == q.loops)) begin
                d.st = ST_IDLE;
                ev[IRQ_DONE] = 1'b1;
            end
        end
        if (stop_req && (q.st != ST_IDLE)) begin
            d.st = ST_IDLE;
            ev[IRQ_DONE] = 1'b1;
        end
        // A new event wins over a clear in the same cycle.
        d.irq_sts = (q.irq_sts & ~w1c) | ev;
    end

    // ========================================
    // State register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q          <= '0;
            q.st       <= ST_IDLE;
            q.mode     <= RST_MODE;
            q.chans    <= RST_CHANS;
            q.irq_mask <= RST_MASK;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata     = q.rdata;
    assign mem_wr        = q.mem_wr;
    assign mem_byte_addr = q.mem_addr;
    assign seg_ready     = q.seg_ready;
    assign seg_byte_base = q.seg_base;
    assign acq_busy      = (q.st != ST_IDLE);
    assign irq           = |(q.irq_sts & q.irq_mask);

    // ========================================
    // Checks
    chk_mode_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
        (q.st == ST_IDLE && start_req && !mode_ok) |=> q.st == ST_IDLE)
        else $error("Start accepted with an unknown mode code.");
    chk_pre_error: assert property (@(posedge clk_sys) disable iff (!rstn)
        (q.st == ST_IDLE && start_req && mode_ok && cfg_bad)
        |=> q.irq_sts[IRQ_ERR] && q.st == ST_IDLE)
        else $error("Bad pre-trigger depth not reported.");
    chk_pre_derived: assert property (@(posedge clk_sys) disable iff (!rstn)
        ($past(q.st) == ST_IDLE && q.st == ST_PRE)
        |-> q.pre == $past(q.seglen) - $past(q.post))
        else $error("Pre-trigger depth not segment minus post.");
    chk_rearm_gap: assert property (@(posedge clk_sys) disable iff (!rstn)
        (seg_end && !stop_req && !ev[IRQ_DONE]) |=> q.st == ST_PRE && q.cnt == RST_CNT)
        else $error("No immediate re-arm after a segment.");
    chk_post_count: assert property (@(posedge clk_sys) disable iff (!rstn)
        (q.st == ST_POST) |-> (q.cnt < q.post) && (q.cnt != RST_CNT))
        else $error("Post-trigger count out of range.");
    chk_seg_bound: assert property (@(posedge clk_sys) disable iff (!rstn)
        (q.st != ST_IDLE) |-> q.ptr < q.seglen)
        else $error("Write pointer left its segment.");
    // A host stop may leave the post phase early, so only a finished segment is counted.
    chk_one_segment: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(seg_end) |-> q.segs == $past(q.segs) + 32'h1)
        else $error("Segment count not advanced once per trigger.");
    chk_bounded_end: assert property (@(posedge clk_sys) disable iff (!rstn)
        (q.st != ST_IDLE && !q.stream) |-> q.filled < q.total)
        else $error("Bounded acquisition ran past the total.");
    chk_loop_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
        (q.st != ST_IDLE && q.stream && q.loops != RST_LOOPS) |-> q.segs < q.loops)
        else $error("Streaming ran past the segment count.");
    chk_stream_only: assert property (@(posedge clk_sys) disable iff (!rstn)
        seg_ready |-> q.stream && $past(seg_end))
        else $error("Segment handed over outside streaming.");
    chk_byte_word: assert property (@(posedge clk_sys) disable iff (!rstn)
        mem_wr |-> mem_byte_addr[0] == 1'b0 && $past(sample_valid))
        else $error("Sample write not on a two-byte word.");
    chk_pre_limit: assert property (@(posedge clk_sys) disable iff (!rstn)
        acq_busy |-> q.pre <= pre_max)
        else $error("Running with a pre-trigger depth above the limit.");
    chk_seg_equal: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(seg_end) |-> (q.base == $past(q.base) + $past(q.seglen)) || (q.base == RST_CNT))
        else $error("Next segment base not one segment length on.");
    chk_post_start: assert property (@(posedge clk_sys) disable iff (!rstn)
        (q.st == ST_PRE && sample_valid && trigger_in && q.cnt >= q.pre && q.post != 64'h1
        && !stop_req) |=> q.st == ST_POST && q.cnt == 64'h1)
        else $error("Trigger sample not counted as first post sample.");
    chk_host_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
        (stop_req && q.st != ST_IDLE) |=> q.st == ST_IDLE && q.irq_sts[IRQ_DONE])
        else $error("Host stop not honoured at once.");
    chk_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
        $past(q.st) == ST_IDLE |-> !mem_wr)
        else $error("Sample written while idle.");
    chk_sticky_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        ($past(q.irq_sts) & ~$past(w1c) & ~q.irq_sts) == '0)
        else $error("Status bit lost without a clear.");
    cov_bounded_done: cover property (@(posedge clk_sys) disable iff (!rstn)
        !q.stream && seg_end && ev[IRQ_DONE]);
    cov_host_stop: cover property (@(posedge clk_sys) disable iff (!rstn)
        stop_req && q.st == ST_POST);
    cov_stream_seg: cover property (@(posedge clk_sys) disable iff (!rstn)
        seg_ready ##[1:200] seg_ready);
    cov_pre_err: cover property (@(posedge clk_sys) disable iff (!rstn)
        ev[IRQ_ERR]);
endmodule

/* File: segacq_host.sv */
// Host driver model: register master and segment programming of the controller.
`timescale 1ns/100ps
module segacq_host
    import segacq_pkg::*;
(
    // Clock
    input  wire logic        clk_sys,
    // Register port
    output logic      [15:0] reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    // ========================================
    // Bus cycles
    initial begin
        reg_addr  = 16'h0000;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // ========================================
    // Segment programming
    task automatic setup(input logic [31:0] mode, input logic [31:0] seg,
                         input logic [31:0] post, input logic [31:0] segs);
        wr(OFF_MODE, mode);
        wr(OFF_SEGLEN_LO, seg);
        wr(OFF_POST_LO, post);
        wr(OFF_TOTAL_LO, seg * segs);
        wr(OFF_LOOPS, segs);
    endtask
endmodule

/* File: segacq_ctrl_tb.sv */
// Self-checking testbench of the segmented acquisition controller.
`timescale 1ns/100ps
module segacq_ctrl_tb
    import segacq_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        sample_valid = 1'b0;
    logic        trigger_in = 1'b0;
    logic        mem_wr;
    logic [63:0] mem_byte_addr;
    logic        seg_ready;
    logic [63:0] seg_byte_base;
    logic        acq_busy;
    logic        irq;
    int          num_errors = 0;
    int          num_checks = 0;
    int          n_wr = 0;
    int          n_seg = 0;
    logic [63:0] max_addr = 64'h0;
    logic [63:0] last_base = 64'h0;

    always #50 clk_sys = ~clk_sys;

    segacq_host i_segacq_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // A small memory keeps the base wrap within reach of a short run.
    segacq_ctrl #(.MEM_SAMPLES(64'h40)) i_segacq_ctrl (.clk_sys(clk_sys), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sample_valid(sample_valid), .trigger_in(trigger_in),
        .mem_wr(mem_wr), .mem_byte_addr(mem_byte_addr), .seg_ready(seg_ready),
        .seg_byte_base(seg_byte_base), .acq_busy(acq_busy), .irq(irq));

    // ========================================
    // Checks and monitors
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %0h", $time, m, got);
        end
    endtask

    task automatic rchk(input logic [15:0] a, input logic [31:0] e, input string m);
        logic [31:0] d;
        i_segacq_host.rd(a, d);
        chk(64'(d), 64'(e), m);
    endtask

    always @(posedge clk_sys) begin
        if (mem_wr === 1'b1) begin
            n_wr <= n_wr + 1;
            chk(64'(mem_byte_addr[0]), 64'h0, "odd byte address");
            if (mem_byte_addr > max_addr) max_addr <= mem_byte_addr;
        end
        if (seg_ready === 1'b1) begin
            n_seg <= n_seg + 1;
            last_base <= seg_byte_base;
        end
    end

    // ========================================
    // Stimulus
    task automatic feed(input int n, input logic trg);
        repeat (n) begin
            @(posedge clk_sys);
            sample_valid <= 1'b1;
            trigger_in   <= trg;
        end
        @(posedge clk_sys);
        sample_valid <= 1'b0;
        trigger_in   <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic start(input logic [31:0] c);
        i_segacq_host.wr(OFF_CTRL, c);
        @(posedge clk_sys);
        #1;
        n_wr = 0;
        n_seg = 0;
        max_addr = 64'h0;
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        rchk(OFF_MODE, RST_MODE, "mode reset");
        rchk(OFF_CHANNELS, 32'(RST_CHANS), "channels reset");
        rchk(16'h2900, 32'h0, "unmapped read");
        start(32'h1);
        chk(64'(acq_busy), 64'h0, "start without mode");
        $display("test reset done");
        // Constant trigger: each segment is pre plus post samples, back to back.
        i_segacq_host.setup(MODE_BOUNDED, 32'h4, 32'h2, 32'h2);
        i_segacq_host.wr(OFF_IRQ_MASK, 32'h2);
        rchk(OFF_PRE, 32'h2, "pre depth");
        start(32'h1);
        feed(12, 1'b1);
        chk(64'(n_wr), 64'h8, "bounded samples");
        chk(max_addr, 64'he, "bounded top address");
        chk(64'(acq_busy), 64'h0, "bounded end");
        chk(64'(irq), 64'h1, "done irq");
        rchk(OFF_SEG_DONE, 32'h2, "segments done");
        i_segacq_host.wr(OFF_IRQ_STS, 32'h7);
        rchk(OFF_IRQ_STS, 32'h0, "status cleared");
        chk(64'(irq), 64'h0, "irq cleared");
        $display("test bounded done");
        i_segacq_host.setup(MODE_STREAM, 32'h4, 32'h2, 32'h3);
        start(32'h1);
        rchk(OFF_STATUS, 32'h3, "streaming busy");
        feed(5, 1'b0);
        feed(1, 1'b1);
        chk(64'(n_seg), 64'h0, "one post sample");
        feed(1, 1'b0);
        chk(64'(n_seg), 64'h1, "post complete");
        feed(12, 1'b1);
        chk(64'(n_seg), 64'h3, "segment count stop");
        chk(last_base, 64'h10, "third base");
        chk(64'(acq_busy), 64'h0, "count reached");
        $display("test streaming done");
        i_segacq_host.setup(MODE_STREAM, 32'h4, 32'h2, 32'h0);
        start(32'h1);
        feed(68, 1'b1);
        chk(64'(n_seg), 64'd17, "endless segments");
        chk(last_base, 64'h0, "base wrap");
        chk(64'(acq_busy), 64'h1, "endless busy");
        feed(3, 1'b1);
        chk(64'(n_seg), 64'd17, "stop in post phase");
        i_segacq_host.wr(OFF_MODE, MODE_BOUNDED);
        start(32'h2);
        chk(64'(acq_busy), 64'h0, "host stop");
        rchk(OFF_MODE, MODE_STREAM, "write while busy");
        $display("test endless done");
        i_segacq_host.wr(OFF_IRQ_STS, 32'h7);
        i_segacq_host.wr(OFF_CHANNELS, 32'(CH_TWO));
        i_segacq_host.setup(MODE_BOUNDED, 32'd4093, 32'h4, 32'h1);
        start(32'h1);
        chk(64'(acq_busy), 64'h0, "pre too long");
        rchk(OFF_IRQ_STS, 32'h4, "pre error");
        chk(64'(irq), 64'h0, "error masked");
        i_segacq_host.wr(OFF_IRQ_MASK, 32'h4);
        rchk(OFF_IRQ_MASK, 32'h4, "mask readback");
        chk(64'(irq), 64'h1, "error unmasked");
        i_segacq_host.setup(MODE_BOUNDED, 32'd4092, 32'h4, 32'h1);
        start(32'h1);
        chk(64'(acq_busy), 64'h1, "pre at limit");
        start(32'h2);
        i_segacq_host.wr(OFF_IRQ_STS, 32'h7);
        i_segacq_host.wr(OFF_CHANNELS, 32'(CH_FOUR));
        i_segacq_host.setup(MODE_BOUNDED, 32'd2049, 32'h4, 32'h1);
        start(32'h1);
        chk(64'(acq_busy), 64'h0, "four channel pre too long");
        rchk(OFF_IRQ_STS, 32'h4, "four channel pre error");
        i_segacq_host.setup(MODE_BOUNDED, 32'd2048, 32'h4, 32'h1);
        start(32'h1);
        chk(64'(acq_busy), 64'h1, "four channel pre at limit");
        start(32'h2);
        $display("test limits done");
        wrap_up();
    end
endmodule
